// file: verilog/sdcpd_pkg.sv
`default_nettype none
package sdcpd_pkg;

    // ----------------------------------------------------------------
    // Pin widths and field positions
    // ----------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int DQ_W = 16;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int LANE_W = 8;
    localparam int LANES = 2;
    localparam int AUTO_PRECHARGE_SELECT_BIT = 10;
    // Write word: bank, row, column, lane enables, data
    localparam int WR_ENTRY_W = BANK_W + ADDR_W + COL_W + LANES + DQ_W;
    localparam int WR_DATA_LSB = 0;
    localparam int WR_BE_LSB = DQ_W;
    localparam int WR_COL_LSB = WR_BE_LSB + LANES;
    localparam int WR_ROW_LSB = WR_COL_LSB + COL_W;
    localparam int WR_BANK_LSB = WR_ROW_LSB + ADDR_W;

    // ----------------------------------------------------------------
    // Timing: mask-to-output latency on reads, in clocks
    // ----------------------------------------------------------------
    localparam int RD_MASK_LAT = 2;

    // ----------------------------------------------------------------
    // Decoded commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_DESELECT = 3'b000,
        CMD_NOP = 3'b001,
        CMD_ROW_OPEN = 3'b010,
        CMD_PRECHARGE = 3'b011,
        CMD_READ = 3'b100,
        CMD_WRITE = 3'b101,
        CMD_MODE_SET = 3'b110,
        CMD_OTHER = 3'b111
    } sdcpd_cmd_e;

    // All four strobes together form the code
    function automatic sdcpd_cmd_e sdcpd_decode(input logic cs_n,
        input logic ras_n, input logic cas_n, input logic we_n);
        sdcpd_cmd_e c;
        case ({cs_n, ras_n, cas_n, we_n})
            4'b0011: c = CMD_ROW_OPEN;
            4'b0010: c = CMD_PRECHARGE;
            4'b0101: c = CMD_READ;
            4'b0100: c = CMD_WRITE;
            4'b0000: c = CMD_MODE_SET;
            4'b0111: c = CMD_NOP;
            default: c = cs_n ? CMD_DESELECT : CMD_OTHER;
        endcase
        return c;
    endfunction

    // Mask high disables a lane
    function automatic logic [LANES-1:0] sdcpd_lane_en(
        input logic [LANES-1:0] mask);
        return ~mask;
    endfunction

endpackage
`default_nettype wire

// file: verilog/sdcpd_word_buf.sv
`default_nettype none
module sdcpd_word_buf
    import sdcpd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WR_ENTRY_W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WR_ENTRY_W-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic v0;
        logic v1;
        logic [WR_ENTRY_W-1:0] d0;
        logic [WR_ENTRY_W-1:0] d1;
    } sdcpd_buf_s;

    sdcpd_buf_s s_reg;
    sdcpd_buf_s s_next;
    logic pop;
    logic push;

    // ----------------------------------------------------------------
    // Two slots; slot 0 is always the head
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        pop = s_reg.v0 & out_ready;
        push = in_valid & ~s_reg.v1;
        if (pop) begin
            s_next.d0 = s_reg.d1;
            s_next.v0 = s_reg.v1;
            s_next.v1 = 1'b0;
        end
        if (push) begin
            if (!s_next.v0) begin
                s_next.d0 = in_data;
                s_next.v0 = 1'b1;
            end else begin
                s_next.d1 = in_data;
                s_next.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign in_ready = ~s_reg.v1;
    assign out_valid = s_reg.v0;
    assign out_data = s_reg.d0;

    buf_order_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_reg.v1 |-> s_reg.v0)
        else $error("second slot full with head empty");

    stall_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("head word changed while stalled");

endmodule // sdcpd_word_buf
`default_nettype wire

// file: verilog/sdcpd_bank_track.sv
`default_nettype none
module sdcpd_bank_track
    import sdcpd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic open_en,
    input wire logic close_en,
    input wire logic close_all,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ADDR_W-1:0] row,
    output logic [NUM_BANKS-1:0] active,
    output logic [ADDR_W-1:0] bank_row
);

    typedef struct packed {
        logic [NUM_BANKS-1:0] active;
        logic [NUM_BANKS-1:0][ADDR_W-1:0] row;
    } sdcpd_bank_s;

    sdcpd_bank_s s_reg;
    sdcpd_bank_s s_next;

    // ----------------------------------------------------------------
    // Per-bank open/idle state and open row
    // ----------------------------------------------------------------
    // Precharge is modelled as finishing in one clock
    always_comb begin
        s_next = s_reg;
        if (close_all) begin
            s_next.active = '0;
        end else if (close_en) begin
            s_next.active[bank] = 1'b0;
        end else if (open_en) begin
            s_next.active[bank] = 1'b1;
            s_next.row[bank] = row;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign active = s_reg.active;
    assign bank_row = s_reg.row[bank];

    open_bank_a: assert property (@(posedge sys_clk) disable iff (rst)
        open_en && !close_en && !close_all |=> active[$past(bank)])
        else $error("opened bank not marked active");

    row_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        open_en && !close_en && !close_all
        |=> s_reg.row[$past(bank)] == $past(row))
        else $error("row not captured on open");

    close_all_a: assert property (@(posedge sys_clk) disable iff (rst)
        close_all |=> active == '0)
        else $error("banks still active after close all");

endmodule // sdcpd_bank_track
`default_nettype wire

// file: verilog/sdcpd_cmd_decoder.sv
`default_nettype none
module sdcpd_cmd_decoder
    import sdcpd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_enable_n,
    input wire logic [BANK_W-1:0] bank_select,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic [LANES-1:0] dq_oe,
    output logic [ADDR_W-1:0] mode_reg,
    output logic [NUM_BANKS-1:0] bank_active,
    output logic [2:0] last_cmd,
    output logic rd_req,
    output logic [BANK_W-1:0] rd_bank,
    output logic [ADDR_W-1:0] rd_row,
    output logic [COL_W-1:0] rd_col,
    output logic rd_auto_precharge,
    input wire logic rd_resp_valid,
    input wire logic [DQ_W-1:0] rd_resp_data,
    output logic wr_valid,
    output logic [BANK_W-1:0] wr_bank,
    output logic [ADDR_W-1:0] wr_row,
    output logic [COL_W-1:0] wr_col,
    output logic [LANES-1:0] wr_lane_en,
    output logic [DQ_W-1:0] wr_data,
    input wire logic wr_ready,
    output logic wr_stall
);

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] mask;
        logic [DQ_W-1:0] dq;
        logic [LANES-1:0] mask_d1;
        logic [ADDR_W-1:0] mode;
        logic [2:0] last_cmd;
        logic rd_req;
        logic [BANK_W-1:0] rd_bank;
        logic [ADDR_W-1:0] rd_row;
        logic [COL_W-1:0] rd_col;
        logic rd_ap;
        logic [DQ_W-1:0] dq_out;
        logic [LANES-1:0] dq_oe;
        logic wr_stall;
    } sdcpd_top_s;

    sdcpd_top_s s_reg;
    sdcpd_top_s s_next;
    sdcpd_cmd_e cmd;
    logic ap_bit;
    logic [LANES-1:0] wr_be;
    logic [DQ_W-1:0] wr_masked;
    logic [WR_ENTRY_W-1:0] wr_entry;
    logic [WR_ENTRY_W-1:0] buf_out;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [ADDR_W-1:0] open_row;
    logic open_en;
    logic close_en;
    logic close_all;

    // ----------------------------------------------------------------
    // Decode of the registered pin sample
    // ----------------------------------------------------------------
    // Decoding from registered pins gives a full clock for the decode
    always_comb begin
        cmd = sdcpd_decode(s_reg.cs_n, s_reg.ras_n, s_reg.cas_n,
            s_reg.we_n);
        ap_bit = s_reg.addr[AUTO_PRECHARGE_SELECT_BIT];
        open_en = (cmd == CMD_ROW_OPEN);
        close_all = (cmd == CMD_PRECHARGE) && ap_bit;
        close_en = ((cmd == CMD_PRECHARGE) && !ap_bit) ||
            (((cmd == CMD_READ) || (cmd == CMD_WRITE)) && ap_bit);
    end

    // ----------------------------------------------------------------
    // Write lanes
    // ----------------------------------------------------------------
    always_comb begin
        wr_be = sdcpd_lane_en(s_reg.mask);
        for (int i = 0; i < LANES; i++) begin
            wr_masked[i*LANE_W +: LANE_W] = wr_be[i] ?
                s_reg.dq[i*LANE_W +: LANE_W] : '0;
        end
        wr_entry = {s_reg.ba, open_row, s_reg.addr[COL_W-1:0], wr_be,
            wr_masked};
        // A fully masked word carries nothing, so it is not queued
        buf_in_valid = (cmd == CMD_WRITE) && (wr_be != '0);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.cs_n = chip_select_n;
        s_next.ras_n = row_strobe_n;
        s_next.cas_n = col_strobe_n;
        s_next.we_n = write_enable_n;
        s_next.ba = bank_select;
        s_next.addr = addr;
        s_next.mask = {upper_byte_mask, lower_byte_mask};
        s_next.dq = dq_in;
        s_next.mask_d1 = s_reg.mask;
        s_next.last_cmd = cmd;
        s_next.rd_req = 1'b0;
        if (cmd == CMD_MODE_SET) begin
            s_next.mode = s_reg.addr;
        end
        if (cmd == CMD_READ) begin
            s_next.rd_req = 1'b1;
            s_next.rd_bank = s_reg.ba;
            s_next.rd_row = open_row;
            s_next.rd_col = s_reg.addr[COL_W-1:0];
            s_next.rd_ap = ap_bit;
        end
        // Lane drivers follow the masks seen RD_MASK_LAT clocks earlier
        s_next.dq_out = rd_resp_data;
        s_next.dq_oe = rd_resp_valid ? sdcpd_lane_en(s_reg.mask_d1)
            : '0;
        // A write refused by a full buffer is flagged, not silently lost
        s_next.wr_stall = ~buf_in_ready | (buf_in_valid & ~buf_in_ready);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.cs_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Bank state and write buffer
    // ----------------------------------------------------------------
    sdcpd_bank_track u_banks (
        .sys_clk(sys_clk),
        .rst(rst),
        .open_en(open_en),
        .close_en(close_en),
        .close_all(close_all),
        .bank(s_reg.ba),
        .row(s_reg.addr),
        .active(bank_active),
        .bank_row(open_row)
    );

    sdcpd_word_buf u_wbuf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(buf_in_valid),
        .in_data(wr_entry),
        .in_ready(buf_in_ready),
        .out_valid(wr_valid),
        .out_data(buf_out),
        .out_ready(wr_ready)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign dq_out = s_reg.dq_out;
    assign dq_oe = s_reg.dq_oe;
    assign mode_reg = s_reg.mode;
    assign last_cmd = s_reg.last_cmd;
    assign rd_req = s_reg.rd_req;
    assign rd_bank = s_reg.rd_bank;
    assign rd_row = s_reg.rd_row;
    assign rd_col = s_reg.rd_col;
    assign rd_auto_precharge = s_reg.rd_ap;
    assign wr_stall = s_reg.wr_stall;
    assign wr_bank = buf_out[WR_BANK_LSB +: BANK_W];
    assign wr_row = buf_out[WR_ROW_LSB +: ADDR_W];
    assign wr_col = buf_out[WR_COL_LSB +: COL_W];
    assign wr_lane_en = buf_out[WR_BE_LSB +: LANES];
    assign wr_data = buf_out[WR_DATA_LSB +: DQ_W];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    mode_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_select_n && !row_strobe_n && !col_strobe_n && !write_enable_n
        ##1 1'b1 |=> mode_reg == $past(addr, 2))
        else $error("mode register did not take the address pins");

    deselect_quiet_a: assert property (@(posedge sys_clk)
        disable iff (rst)
        chip_select_n ##1 1'b1 |=> !rd_req && $stable(mode_reg))
        else $error("command acted on while deselected");

    nop_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_select_n && row_strobe_n && col_strobe_n && write_enable_n
        ##1 1'b1 |=> !rd_req && $stable(mode_reg)
        && $stable(bank_active))
        else $error("no-op changed state");

    read_req_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_select_n && row_strobe_n && !col_strobe_n && write_enable_n
        |=> ##1 rd_req && rd_col == $past(addr[COL_W-1:0], 2)
        && rd_auto_precharge == $past(addr[AUTO_PRECHARGE_SELECT_BIT], 2))
        else $error("read not issued with sampled column");

    precharge_one_a: assert property (@(posedge sys_clk)
        disable iff (rst)
        !chip_select_n && !row_strobe_n && col_strobe_n && !write_enable_n
        && !addr[AUTO_PRECHARGE_SELECT_BIT]
        |=> ##1 !bank_active[$past(bank_select, 2)])
        else $error("precharged bank still active");

    read_oe_lanes_a: assert property (@(posedge sys_clk)
        disable iff (rst)
        rd_resp_valid |=> dq_oe[0] == !$past(lower_byte_mask, 3)
        && dq_oe[1] == !$past(upper_byte_mask, 3))
        else $error("read drivers disobey masks two clocks back");

    write_lane_a: assert property (@(posedge sys_clk) disable iff (rst)
        buf_in_valid && s_reg.mask == 2'b01
        |-> wr_entry[WR_DATA_LSB +: LANE_W] == '0
        && wr_entry[WR_DATA_LSB + LANE_W +: LANE_W] == s_reg.dq[15:8])
        else $error("lower lane not dropped independently");

    idle_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        !rd_resp_valid |=> dq_oe == '0)
        else $error("data bus driven with no read data");

    ap_close_a: assert property (@(posedge sys_clk) disable iff (rst)
        ((cmd == CMD_READ) || (cmd == CMD_WRITE)) && ap_bit
        |=> !bank_active[$past(s_reg.ba)])
        else $error("auto precharge left the bank open");

    precharge_all_a: assert property (@(posedge sys_clk)
        disable iff (rst)
        !chip_select_n && !row_strobe_n && col_strobe_n && !write_enable_n
        && addr[AUTO_PRECHARGE_SELECT_BIT] |=> ##1 bank_active == '0)
        else $error("precharge all left a bank open");

    row_open_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_select_n && !row_strobe_n && col_strobe_n && write_enable_n
        |=> ##1 bank_active[$past(bank_select, 2)]
        && last_cmd == CMD_ROW_OPEN)
        else $error("row open not decoded");

    deselect_code_a: assert property (@(posedge sys_clk)
        disable iff (rst) chip_select_n |=> ##1 last_cmd == CMD_DESELECT)
        else $error("deselect not reported as deselect");

    read_bank_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_select_n && row_strobe_n && !col_strobe_n && write_enable_n
        |=> ##1 rd_bank == $past(bank_select, 2))
        else $error("read not aimed at the selected bank");

    masked_write_a: assert property (@(posedge sys_clk)
        disable iff (rst)
        !chip_select_n && row_strobe_n && !col_strobe_n && !write_enable_n
        && lower_byte_mask && upper_byte_mask |=> !buf_in_valid)
        else $error("fully masked write queued");

    write_push_a: assert property (@(posedge sys_clk) disable iff (rst)
        buf_in_valid && buf_in_ready |=> wr_valid)
        else $error("accepted write word not offered");

    upper_lane_a: assert property (@(posedge sys_clk) disable iff (rst)
        buf_in_valid && s_reg.mask == 2'h2
        |-> wr_entry[WR_DATA_LSB + LANE_W +: LANE_W] == '0
        && wr_entry[WR_DATA_LSB +: LANE_W] == s_reg.dq[7:0])
        else $error("upper lane not dropped independently");

    other_code_a: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_select_n && row_strobe_n && col_strobe_n && !write_enable_n
        |=> ##1 !rd_req && $stable(bank_active) && $stable(mode_reg))
        else $error("unsupported code acted on");

    cs_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_reg.cs_n |-> cmd == CMD_DESELECT && !buf_in_valid)
        else $error("decoder enabled while deselected");

endmodule // sdcpd_cmd_decoder
`default_nettype wire

// file: verif/sdcpd_ctrl_model.sv
`default_nettype none
module sdcpd_ctrl_model (
    input wire logic sys_clk,
    output var logic chip_select_n,
    output var logic row_strobe_n,
    output var logic col_strobe_n,
    output var logic write_enable_n,
    output var logic [1:0] bank_select,
    output var logic [12:0] addr,
    output var logic lower_byte_mask,
    output var logic upper_byte_mask,
    output var logic [15:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hF;
        bank_select = 2'h0;
        addr = 13'h0000;
        {upper_byte_mask, lower_byte_mask} = 2'h3;
        dq = 16'h0000;
    end

    // ------------------------------------------------------------
    // Command held across exactly one sampling edge
    // ------------------------------------------------------------
    task automatic issue(input logic [3:0] code, input logic [1:0] bank,
        input logic [12:0] a, input logic [1:0] mask, input logic [15:0] d);
        {chip_select_n, row_strobe_n, col_strobe_n,
            write_enable_n} = code;
        bank_select = bank;
        addr = a;
        {upper_byte_mask, lower_byte_mask} = mask;
        dq = d;
        @(posedge sys_clk);
        #1;
    endtask

    // Released address and data lines flip so a stale value never looks valid
    task automatic idle();
        {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hF;
        addr = ~addr;
        dq = ~dq;
        {upper_byte_mask, lower_byte_mask} = 2'h3;
    endtask
endmodule // sdcpd_ctrl_model
`default_nettype wire

// file: verif/sdcpd_cmd_decoder_tb.sv
`default_nettype none
module sdcpd_cmd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sdcpd_pkg::*;

    localparam logic [3:0] C_OPEN = 4'h3, C_PRE = 4'h2, C_RD = 4'h5;
    localparam logic [3:0] C_WR = 4'h4, C_MRS = 4'h0;
    logic sys_clk = 1'b0;
    logic rst, cs_n, ras_n, cas_n, we_n, lmask, umask;
    logic [1:0] bank_select, dq_oe, wr_lane_en;
    logic [12:0] addr, mode_reg, rd_row, wr_row;
    logic [15:0] ctrl_dq, dq_in, dq_out, rd_resp_data, wr_data;
    logic [3:0] bank_active;
    logic [2:0] last_cmd;
    logic rd_req, rd_ap, rd_resp_valid, wr_valid, wr_ready, wr_stall;
    logic [1:0] rd_bank, wr_bank;
    logic [9:0] rd_col, wr_col;
    logic [12:0] rows [4] = '{13'h0000, 13'h0A51, 13'h1542, 13'h1FFF};
    int errors = 0;
    int checked = 0;

    always #10 sys_clk = ~sys_clk;
    assign dq_in = {dq_oe[1] ? dq_out[15:8] : ctrl_dq[15:8],
        dq_oe[0] ? dq_out[7:0] : ctrl_dq[7:0]};

    sdcpd_ctrl_model u_ctrl (.sys_clk(sys_clk), .chip_select_n(cs_n),
        .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_enable_n(we_n),
        .bank_select(bank_select), .addr(addr), .lower_byte_mask(lmask),
        .upper_byte_mask(umask), .dq(ctrl_dq));

    sdcpd_cmd_decoder u_dut (.sys_clk(sys_clk), .rst(rst),
        .chip_select_n(cs_n), .row_strobe_n(ras_n), .col_strobe_n(cas_n),
        .write_enable_n(we_n), .bank_select(bank_select), .addr(addr),
        .lower_byte_mask(lmask), .upper_byte_mask(umask), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .mode_reg(mode_reg),
        .bank_active(bank_active), .last_cmd(last_cmd), .rd_req(rd_req),
        .rd_bank(rd_bank), .rd_row(rd_row), .rd_col(rd_col),
        .rd_auto_precharge(rd_ap), .rd_resp_valid(rd_resp_valid),
        .rd_resp_data(rd_resp_data), .wr_valid(wr_valid),
        .wr_bank(wr_bank), .wr_row(wr_row), .wr_col(wr_col),
        .wr_lane_en(wr_lane_en), .wr_data(wr_data), .wr_ready(wr_ready),
        .wr_stall(wr_stall));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_select();
        u_ctrl.issue(C_MRS, 2'h0, 13'h1A5A, 2'h3, 16'h0000);
        u_ctrl.issue(4'h8, 2'h0, 13'h0123, 2'h3, 16'h0000);
        u_ctrl.issue(4'hB, 2'h2, 13'h0123, 2'h3, 16'h0000);
        u_ctrl.issue(4'h6, 2'h1, 13'h0777, 2'h3, 16'h0000);
        u_ctrl.issue(4'h1, 2'h3, 13'h0999, 2'h3, 16'h0000);
        u_ctrl.issue(4'h7, 2'h1, 13'h1555, 2'h0, 16'hFFFF);
        u_ctrl.idle();
        step(2);
        chk(16'(mode_reg), 16'h1A5A, "mode load");
        chk(16'(last_cmd), 16'(CMD_DESELECT), "deselect code");
        chk(16'(bank_active), 16'h0000, "no open");
        $display("test select done");
    endtask

    task automatic t_open_read();
        for (int b = 0; b < 4; b++) begin
            u_ctrl.issue(C_OPEN, 2'(b), rows[b], 2'h3, 16'h0000);
            u_ctrl.idle();
            step();
            chk(16'(bank_active), 16'((1 << (b + 1)) - 1), "open");
            chk(16'(last_cmd), 16'(CMD_ROW_OPEN), "code");
        end
        for (int b = 0; b < 4; b++) begin
            u_ctrl.issue(C_RD, 2'(b), 13'(10'h3FF - b), 2'h3, 16'h0000);
            u_ctrl.idle();
            step();
            chk(16'({rd_req, rd_ap, rd_bank}), 16'(8 + b), "rd");
            chk(16'(rd_row), 16'(rows[b]), "rd row");
            chk(16'(rd_col), 16'(10'h3FF - b), "rd col");
            step();
            chk(16'(rd_req), 16'h0000, "rd pulse");
        end
        u_ctrl.issue(C_RD, 2'h2, 13'h1C00, 2'h3, 16'h0000);
        u_ctrl.idle();
        step();
        chk(16'({rd_req, rd_ap, rd_col}), 16'h0C00, "rd ap");
        step();
        chk(16'(bank_active), 16'h000B, "ap close");
        u_ctrl.issue(C_PRE, 2'h1, 13'h1BFF, 2'h3, 16'h0000);
        u_ctrl.idle();
        step(2);
        chk(16'(bank_active), 16'h0009, "pre one");
        u_ctrl.issue(C_PRE, 2'h1, 13'h0400, 2'h3, 16'h0000);
        u_ctrl.idle();
        step(2);
        chk(16'(bank_active), 16'h0000, "pre all");
        $display("test open read done");
    endtask

    task automatic t_write();
        logic [15:0] d;
        for (int m = 0; m < 4; m++) begin
            d = 16'hC3A5 ^ 16'(m);
            u_ctrl.issue(C_OPEN, 2'(m), rows[m], 2'h3, 16'h0000);
            u_ctrl.issue(C_WR, 2'(m), 13'h0455, 2'(m), d);
            u_ctrl.idle();
            step();
            chk(16'(wr_valid), 16'(m != 3), "wr valid");
            chk(16'(bank_active), 16'h0000, "wr ap close");
            if (m != 3) begin
                chk(16'({wr_bank, wr_lane_en}), 16'(m * 4 + 3 - m), "wr");
                chk(wr_data, d & {{8{~m[1]}}, {8{~m[0]}}}, "wr data");
                chk(16'(wr_row), 16'(rows[m]), "wr row");
                chk(16'(wr_col), 16'h0055, "wr col");
                wr_ready = 1'b1;
                step();
                wr_ready = 1'b0;
                chk(16'(wr_valid), 16'h0000, "pop");
            end
        end
        $display("test write done");
    endtask

    task automatic t_buffer();
        u_ctrl.issue(C_WR, 2'h0, 13'h0001, 2'h0, 16'h1111);
        u_ctrl.issue(C_WR, 2'h1, 13'h0002, 2'h0, 16'h2222);
        u_ctrl.idle();
        step(3);
        chk(16'(wr_stall), 16'h0001, "full");
        u_ctrl.issue(C_WR, 2'h3, 13'h0003, 2'h0, 16'h3333);
        u_ctrl.idle();
        step(2);
        chk(wr_data, 16'h1111, "head held");
        wr_ready = 1'b1;
        step();
        chk(16'({wr_bank, wr_col}), 16'h0402, "second");
        chk(wr_data, 16'h2222, "second data");
        step();
        wr_ready = 1'b0;
        chk(16'({wr_valid, wr_stall}), 16'h0000, "drained");
        $display("test buffer done");
    endtask

    task automatic t_read_mask();
        logic [15:0] d;
        logic [15:0] keep;
        for (int m = 0; m < 4; m++) begin
            d = 16'h9C63 ^ 16'(m << 4);
            keep = {{8{~m[1]}}, {8{~m[0]}}};
            u_ctrl.issue(C_RD, 2'h0, 13'h0010, 2'(m), 16'h0000);
            u_ctrl.idle();
            step();
            rd_resp_valid = 1'b1;
            rd_resp_data = d;
            step();
            rd_resp_valid = 1'b0;
            chk(16'(dq_oe), 16'(~m & 3), "oe lanes");
            chk(dq_out & keep, d & keep, "rd data");
            step();
            chk(16'(dq_oe), 16'h0000, "oe off");
        end
        $display("test read mask done");
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        rd_resp_valid = 1'b0;
        rd_resp_data = 16'h0000;
        wr_ready = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk(16'({dq_oe, rd_req, wr_valid, bank_active}), 16'h0000, "reset");
        chk(16'(mode_reg), 16'h0000, "reset mode");
        step();
        t_select();
        t_open_read();
        t_write();
        t_buffer();
        t_read_mask();
        test_done();
    end

    // Whole run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        test_done();
    end
endmodule // sdcpd_cmd_decoder_tb
`default_nettype wire
